// ### rtl/dsf_device.sv
// Device end: serial frame receiver and converter code register
//
// Overview of operation
// - Low frame sync enables shifting on clocks
// - Shift data in on each falling clock up to the 24th of the frame
// - Update converter after 24th edge
// - Early frame sync rise discards partial frame
// - Host keeps serial clock at most 30MHz
// - Output zero until first valid write
// - Power-down commanded through serial frame
`timescale 1ns/100ps
module dsf_device
   import dsf_pkg::*;
#(
   // Frame geometry
   parameter int FRAME_W = FRAME_BITS,
   parameter int CODE_W = CODE_BITS,
   parameter int CNT_W = BIT_CNT_W
)(
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   // Serial link
   dsf_link_if.dev link,
   // Converter side
   output logic [CODE_W-1:0] analog_output_code_out,
   output logic powered_down_out,
   output logic update_out,
   output logic abort_out
);
   // ****************************************
   // Parameter checks
   // ****************************************
   // Code at the bottom, power-down bit above it, both inside the frame
   localparam int PDN_BIT = CODE_LSB + CODE_W + CTRL_PDN_POS;
   if (CODE_W < 1 || PDN_BIT >= FRAME_W) begin : g_bad_code
      $error("CODE_W leaves no room for the power-down bit");
   end
   // The bit counter must reach the last bit of a frame
   if (FRAME_W < 2 || (FRAME_W - 1) >= (1 << CNT_W)) begin : g_bad_cnt
      $error("CNT_W too narrow for FRAME_W");
   end

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Pin order: 0 frame sync, 1 serial clock, 2 data
   localparam int PIN_N = 3;
   localparam logic [PIN_N-1:0] PIN_IDLE = {SDATA_IDLE, SCLK_IDLE, SYNC_IDLE};
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_sync;
   assign pin_raw = {link.sdata, link.sclk, link.frame_sync_n};

   // Both stages reset to the idle level, so no false edge follows reset
   for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      logic meta_reg, meta_next;
      logic hold_reg, hold_next;

      always_comb begin
         meta_next = pin_raw[i];
         hold_next = meta_reg;
      end

      always_ff @(posedge clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            meta_reg <= PIN_IDLE[i];
            hold_reg <= PIN_IDLE[i];
         end else if (clk_en_in) begin
            meta_reg <= meta_next;
            hold_reg <= hold_next;
         end
      end

      assign pin_sync[i] = hold_reg;
   end

   // ****************************************
   // Serial clock edge detection
   // ****************************************
   logic sclk_last_reg, sclk_last_next;
   logic sync_low;
   logic sdata_bit;
   logic sclk_fall;

   assign sync_low = !pin_sync[0];
   assign sdata_bit = pin_sync[2];
   // Data and clock pass equal stages, so the bit read at a fall
   // is the one that stood at the pin when the clock fell
   assign sclk_fall = sclk_last_reg && !pin_sync[1];

   always_comb begin
      sclk_last_next = pin_sync[1];
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sclk_last_reg <= SCLK_IDLE;
      end else if (clk_en_in) begin
         sclk_last_reg <= sclk_last_next;
      end
   end

   // ****************************************
   // Frame state and shift register
   // ****************************************
   // Full waits for sync to rise, so clocks beyond the last bit change nothing
   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_SHIFT = 2'b01,
      FR_FULL = 2'b10
   } dsf_frame_t;

   dsf_frame_t fr_reg, fr_next;
   logic [FRAME_W-1:0] shift_reg, shift_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [FRAME_W-1:0] word;
   logic take;

   always_comb begin
      fr_next = fr_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      word = {shift_reg[FRAME_W-2:0], sdata_bit};
      take = 1'b0;
      case (fr_reg)
         FR_IDLE: begin
            // A fall in the cycle that sync goes low already counts
            if (sync_low) begin
               fr_next = FR_SHIFT;
               take = sclk_fall;
            end
         end
         FR_SHIFT: begin
            if (sync_low) begin
               take = sclk_fall;
            end else begin
               // Early rise: the partial word is dropped, count restarts
               cnt_next = '0;
               fr_next = FR_IDLE;
            end
         end
         FR_FULL: begin
            if (!sync_low) begin
               fr_next = FR_IDLE;
            end
         end
         default: fr_next = FR_IDLE;
      endcase
      if (take) begin
         shift_next = word;
         if (cnt_reg == CNT_W'(FRAME_W - 1)) begin
            fr_next = FR_FULL;
            cnt_next = '0;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fr_reg <= FR_IDLE;
         shift_reg <= '0;
         cnt_reg <= '0;
      end else if (clk_en_in) begin
         fr_reg <= fr_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************
   // Converter register and pulses
   // ****************************************
   logic [CODE_W-1:0] code_reg, code_next;
   logic pdn_reg, pdn_next;
   logic upd_reg, upd_next;
   logic abt_reg, abt_next;
   logic last_bit;

   // Last bit taken while sync is still low completes a valid write
   assign last_bit = take && cnt_reg == CNT_W'(FRAME_W - 1);

   always_comb begin
      code_next = code_reg;
      pdn_next = pdn_reg;
      upd_next = last_bit;
      // Only a rise after at least one bit counts as an interrupted write
      abt_next = fr_reg == FR_SHIFT && !sync_low && cnt_reg != '0;
      if (last_bit) begin
         // Power-down frames still load the code
         code_next = word[CODE_LSB +: CODE_W];
         pdn_next = word[PDN_BIT];
      end
   end

   // Zero code until the first complete write
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         code_reg <= CODE_W'(CODE_RESET);
         pdn_reg <= CTRL_RESET[CTRL_PDN_POS];
         upd_reg <= 1'b0;
         abt_reg <= 1'b0;
      end else if (clk_en_in) begin
         code_reg <= code_next;
         pdn_reg <= pdn_next;
         upd_reg <= upd_next;
         abt_reg <= abt_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign analog_output_code_out = code_reg;
   assign powered_down_out = pdn_reg;
   assign update_out = upd_reg;
   assign abort_out = abt_reg;
endmodule : dsf_device

// ### rtl/dsf_host.sv
// Host end: sends one 24-bit frame per request, MSB first
`timescale 1ns/100ps
module dsf_host
   import dsf_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
)(
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   // Request
   input wire logic start_in,
   input wire logic [FRAME_BITS-1:0] frame_in,
   input wire logic abort_in,
   output logic busy_out,
   output logic done_out,
   // Serial link
   dsf_link_if.host link
);
   // Serial clock period must respect the converter maximum rate
   if (2 * HALF_CYC < SCLK_MIN_CYC || HALF_CYC > 255) begin : g_bad_half
      $error("HALF_CYC out of range");
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HIGH = 2'b01,
      ST_LOW = 2'b10,
      ST_END = 2'b11
   } dsf_hstate_t;

   dsf_hstate_t st_reg, st_next;
   logic [7:0] div_reg, div_next;
   logic [BIT_CNT_W-1:0] bit_reg, bit_next;
   logic [FRAME_BITS-1:0] sh_reg, sh_next;
   logic fs_reg, fs_next;
   logic ck_reg, ck_next;
   logic done_reg, done_next;
   logic busy_reg, busy_next;
   logic tick;
   assign tick = div_reg == 8'(HALF_CYC - 1);

   always_comb begin
      st_next = st_reg;
      div_next = tick ? 8'h00 : div_reg + 8'h01;
      bit_next = bit_reg;
      sh_next = sh_reg;
      fs_next = fs_reg;
      ck_next = ck_reg;
      done_next = 1'b0;
      case (st_reg)
         ST_IDLE: begin
            div_next = 8'h00;
            if (start_in) begin
               sh_next = frame_in;
               fs_next = 1'b0;
               bit_next = '0;
               st_next = ST_HIGH;
            end
         end
         ST_HIGH: if (tick) begin
            ck_next = 1'b0;
            st_next = ST_LOW;
         end
         ST_LOW: if (tick) begin
            ck_next = 1'b1;
            sh_next = {sh_reg[FRAME_BITS-2:0], 1'b0};
            if (bit_reg == BIT_CNT_W'(FRAME_BITS - 1)) begin
               st_next = ST_END;
            end else begin
               bit_next = bit_reg + 1'b1;
               st_next = ST_HIGH;
            end
         end
         ST_END: if (tick) begin
            fs_next = 1'b1;
            done_next = 1'b1;
            st_next = ST_IDLE;
         end
         default: st_next = ST_IDLE;
      endcase
      if (abort_in && st_reg != ST_IDLE) begin
         fs_next = 1'b1;
         ck_next = 1'b1;
         st_next = ST_IDLE;
      end
      busy_next = st_next != ST_IDLE;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_reg <= ST_IDLE;
         div_reg <= 8'h00;
         bit_reg <= '0;
         sh_reg <= '0;
         fs_reg <= 1'b1;
         ck_reg <= 1'b1;
         done_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (clk_en_in) begin
         st_reg <= st_next;
         div_reg <= div_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         fs_reg <= fs_next;
         ck_reg <= ck_next;
         done_reg <= done_next;
         busy_reg <= busy_next;
      end
   end

   assign link.frame_sync_n = fs_reg;
   assign link.sclk = ck_reg;
   assign link.sdata = sh_reg[FRAME_BITS-1];
   assign busy_out = busy_reg;
   assign done_out = done_reg;
endmodule : dsf_host

// ### rtl/dsf_link_if.sv
// Interface carrying the three-wire serial write link
`timescale 1ns/100ps
interface dsf_link_if;
   logic frame_sync_n;
   logic sclk;
   logic sdata;
   modport host (output frame_sync_n, output sclk, output sdata);
   modport dev (input frame_sync_n, input sclk, input sdata);
endinterface : dsf_link_if

// ### rtl/dsf_pkg.sv
// Package with constants shared by both ends of the serial converter write link
package dsf_pkg;
   // ****************************************
   // Frame layout
   // ****************************************
   localparam int FRAME_BITS = 24;
   localparam int CODE_BITS = 16;
   localparam int CTRL_BITS = FRAME_BITS - CODE_BITS;
   localparam int CODE_LSB = 0;
   localparam int CTRL_LSB = CODE_BITS;
   // Control field: bit 0 of the control byte requests power-down
   localparam int CTRL_PDN_POS = 0;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 16'h0000;
   localparam logic [CTRL_BITS-1:0] CTRL_RESET = 8'h00;
   // Idle levels of the link pins
   localparam logic SYNC_IDLE = 1'b1;
   localparam logic SCLK_IDLE = 1'b1;
   localparam logic SDATA_IDLE = 1'b0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int SCLK_MAX_MHZ = 30;
   // Least serial clock period in system cycles, rounded up
   localparam int SCLK_MIN_CYC = (1000 + SCLK_MAX_MHZ * CLK_PERIOD_NS - 1)
                                 / (SCLK_MAX_MHZ * CLK_PERIOD_NS);
   // Default half period of the host divider (cycles)
   localparam int SCLK_HALF_CYC = 8;
   localparam int BIT_CNT_W = 5;
endpackage : dsf_pkg

// ### tb/dsf_link_monitor.sv
// Checker for the serial link and the device's update and abort pulses
`timescale 1ns/100ps
module dsf_link_monitor
   import dsf_pkg::*;
(
   // Clock, reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Link, device outputs
   input wire logic frame_sync_n,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic [CODE_BITS-1:0] analog_output_code_out,
   input wire logic update_out,
   input wire logic abort_out
);
   // ****
   // Falls per frame, held until the next frame opens
   // ****
   logic sclk_reg, sclk_next, sync_reg, sync_next;
   logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
   always_comb begin
      sclk_next = sclk;
      sync_next = frame_sync_n;
      cnt_next = cnt_reg;
      if (sync_reg && !frame_sync_n) cnt_next = 5'h00;
      else if (!frame_sync_n && sclk_reg && !sclk) cnt_next = cnt_reg + 5'h01;
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sclk_reg <= 1'b1;
         sync_reg <= 1'b1;
         cnt_reg <= 5'h00;
      end else begin
         sclk_reg <= sclk_next;
         sync_reg <= sync_next;
         cnt_reg <= cnt_next;
      end
   end
   // ****
   // Properties; phases assume the default host half period of 8
   // ****
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   clk_idle_a: assert property (frame_sync_n |-> sclk)
      else $error("clock low outside frame");
   frame_lead_a: assert property ($fell(frame_sync_n) |-> sclk [*8])
      else $error("short lead-in");
   low_phase_a: assert property ($fell(sclk) |=> !sclk [*7])
      else $error("short low phase");
   data_steady_a: assert property (!sclk |-> $stable(sdata))
      else $error("data moved while clock low");
   update_count_a: assert property (update_out |-> cnt_reg == 5'h18)
      else $error("update not after 24 falls");
   abort_count_a: assert property (abort_out |-> cnt_reg != 5'h00 && cnt_reg < 5'h18)
      else $error("abort with wrong count");
   code_hold_a: assert property ($changed(analog_output_code_out) |-> update_out)
      else $error("code moved without update");
   frame_len_a: assert property (cnt_reg <= 5'h18)
      else $error("frame over 24 bits");
endmodule : dsf_link_monitor

// ### tb/tb_dac_serial_input_frame.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/100ps
module tb_dac_serial_input_frame;
   import dsf_pkg::*;
   // ****
   // Signals and instances
   // ****
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic start_in = 1'b0;
   logic abort_in = 1'b0;
   logic clk_en = 1'b1;
   logic [FRAME_BITS-1:0] frame_in = 24'h000000;
   logic [FRAME_BITS-1:0] cap;
   logic [CODE_BITS-1:0] analog_output_code_out;
   logic busy_out, done_out, update_out, abort_out, powered_down_out, sclk_q;
   int fail_count = 0, checks_done = 0, cyc = 0, upd_n = 0, abt_n = 0, falls = 0;
   dsf_link_if link();
   dsf_host i_dsf_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en),
      .start_in(start_in), .frame_in(frame_in), .abort_in(abort_in), .busy_out(busy_out),
      .done_out(done_out), .link(link));
   dsf_device i_dsf_device (.clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en),
      .link(link), .analog_output_code_out(analog_output_code_out),
      .powered_down_out(powered_down_out), .update_out(update_out), .abort_out(abort_out));
   dsf_link_monitor i_dsf_link_monitor (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .frame_sync_n(link.frame_sync_n), .sclk(link.sclk), .sdata(link.sdata),
      .analog_output_code_out(analog_output_code_out), .update_out(update_out),
      .abort_out(abort_out));
   initial forever #2 clk_in = ~clk_in;
   // Wire bits are taken at each falling serial clock, independent of the device
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      sclk_q <= link.sclk;
      if (update_out === 1'b1) upd_n <= upd_n + 1;
      if (abort_out === 1'b1) abt_n <= abt_n + 1;
      if (link.frame_sync_n === 1'b0 && sclk_q === 1'b1 && link.sclk === 1'b0) begin
         cap <= {cap[FRAME_BITS-2:0], link.sdata};
         falls <= falls + 1;
      end
      if (cyc == 5000) conclude(1'b1);
   end
   // ****
   // Tasks
   // ****
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic launch(input logic [FRAME_BITS-1:0] f);
      @(posedge clk_in);
      frame_in <= f;
      start_in <= 1'b1;
      @(posedge clk_in);
      start_in <= 1'b0;
   endtask : launch
   task automatic t_write(input logic [FRAME_BITS-1:0] f);
      int f0 = falls;
      int u0 = upd_n;
      launch(f);
      for (int i = 0; i < 600 && done_out !== 1'b1; i++) @(negedge clk_in);
      repeat (2) @(negedge clk_in);
      check("wire bits", f, cap);
      check("falls", 24'h000018, 24'(falls - f0));
      check("updates", 24'h000001, 24'(upd_n - u0));
      check("code", 24'(f[15:0]), 24'(analog_output_code_out));
      check("power-down", 24'(f[16]), 24'(powered_down_out));
   endtask : t_write
   // Aborted before any valid write, so the code must still read zero
   task automatic t_abort();
      int f0 = falls;
      int u0 = upd_n;
      int a0 = abt_n;
      launch(24'h001234);
      for (int i = 0; i < 400 && !(falls - f0 == 10 && link.sclk === 1'b1); i++) @(negedge clk_in);
      @(posedge clk_in);
      abort_in <= 1'b1;
      @(posedge clk_in);
      abort_in <= 1'b0;
      for (int i = 0; i < 50 && busy_out !== 1'b0; i++) @(negedge clk_in);
      repeat (8) @(negedge clk_in);
      check("aborts", 24'h000001, 24'(abt_n - a0));
      check("updates", 24'h000000, 24'(upd_n - u0));
      check("code", 24'h000000, 24'(analog_output_code_out));
   endtask : t_abort
   // Both ends frozen mid-frame: the link stands still, then the frame completes
   task automatic t_freeze();
      int f0 = falls;
      int u0 = upd_n;
      logic [2:0] pins;
      launch(24'h005a5a);
      for (int i = 0; i < 400 && falls - f0 != 5; i++) @(negedge clk_in);
      @(posedge clk_in);
      clk_en <= 1'b0;
      @(negedge clk_in);
      pins = {link.frame_sync_n, link.sclk, link.sdata};
      repeat (20) @(negedge clk_in);
      check("frozen link", 24'(pins), 24'({link.frame_sync_n, link.sclk, link.sdata}));
      check("frozen updates", 24'h000000, 24'(upd_n - u0));
      @(posedge clk_in);
      clk_en <= 1'b1;
      for (int i = 0; i < 600 && done_out !== 1'b1; i++) @(negedge clk_in);
      repeat (2) @(negedge clk_in);
      check("falls", 24'(FRAME_BITS), 24'(falls - f0));
      check("updates", 24'h000001, 24'(upd_n - u0));
      check("code", 24'h005a5a, 24'(analog_output_code_out));
   endtask : t_freeze
   task automatic conclude(input logic hung);
      if (hung) fail_count++;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   initial begin
      repeat (5) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(negedge clk_in);
      check("reset code", 24'h000000, 24'(analog_output_code_out));
      t_abort();
      t_write(24'h00a5c3);
      t_write(24'h01ffff);
      t_write(24'h000001);
      t_freeze();
      conclude(1'b0);
   end
endmodule : tb_dac_serial_input_frame
